/* File: hdl/rcdu_pkg.sv */
// constants shared by the receiver clock divider unit
package rcdu_pkg;
  // register offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // control register fields
  localparam int CTRL_CLKSEL_LSB = 0;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_ENABLE_BIT = 4;
  localparam int CTRL_RX_BIT = 5;
  localparam logic [1:0] CLKSEL_RESET = 2'h0;
  localparam logic [1:0] RATE_RESET = 2'h0;
  // status register fields
  localparam int STAT_OSC_GOOD_BIT = 0;
  localparam int STAT_SUPPLY_BIT = 1;
  localparam int STAT_OSC_RUN_BIT = 2;
  localparam int STAT_RX_PATH_BIT = 3;
  localparam int STAT_RX_READY_BIT = 4;
  localparam int STAT_CLKOUT_EN_BIT = 5;
  localparam int STAT_DATA_BIT = 6;
  // clock output select codes and divider terminal counts
  localparam logic [1:0] CLKSEL_OFF = 2'h0;
  localparam logic [1:0] CLKSEL_DIV3 = 2'h1;
  localparam logic [1:0] CLKSEL_DIV6 = 2'h2;
  localparam logic [1:0] CLKSEL_DIV12 = 2'h3;
  localparam logic [3:0] DIV3_LAST = 4'h2;
  localparam logic [3:0] DIV6_LAST = 4'h5;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  // base clock and range-scaled clock ratios (terminal counts)
  localparam logic [3:0] BASE_LAST = 4'hf;
  localparam logic [3:0] RANGE0_LAST = 4'h7;
  localparam logic [3:0] RANGE1_LAST = 4'h3;
  localparam logic [3:0] RANGE2_LAST = 4'h1;
  localparam logic [3:0] RANGE3_LAST = 4'h0;
  // synthesizer feedback terminal counts
  localparam logic [4:0] FB_LAST_315 = 5'h17;
  localparam logic [4:0] FB_LAST_433 = 5'h1f;
  // receive path timing in range-scaled ticks
  localparam logic [3:0] DEBOUNCE_TICKS = 4'h4;
  localparam logic [7:0] STARTUP_TICKS = 8'h40;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/tick_divider.sv */
// cycle counter that emits a one-cycle tick every last+1 steps
`timescale 1ns/1ps
module tick_divider #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic hold,
  input wire logic step,
  input wire logic [W-1:0] last,
  // tick out
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tick_state_t;

  tick_state_t s_q, s_d;

  assign tick = step && !hold && (s_q.cnt >= last);

  always_comb begin
    s_d = s_q;
    if (hold) begin
      s_d.cnt = '0;
    end else if (step) begin
      s_d.cnt = tick ? '0 : W'(s_q.cnt + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // tick_divider

/* File: hdl/clkout_divider.sv */
// divided clock output with even high and low time, odd ratios included
`timescale 1ns/1ps
module clkout_divider
  import rcdu_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic en,
  input wire logic [1:0] sel,
  // clock out
  output logic clk_out
);
  typedef struct packed {
    logic [3:0] cnt;
    logic pos;
  } div_state_t;

  div_state_t s_q, s_d;
  logic neg_q;
  logic [3:0] last;
  logic odd;

  always_comb begin
    unique case (sel)
      CLKSEL_DIV3: last = DIV3_LAST;
      CLKSEL_DIV6: last = DIV6_LAST;
      CLKSEL_DIV12: last = DIV12_LAST;
      CLKSEL_OFF: last = DIV3_LAST;
    endcase
  end

  assign odd = (sel == CLKSEL_DIV3);

  always_comb begin
    s_d = s_q;
    if (!en) begin
      s_d = '0;
    end else begin
      s_d.cnt = (s_q.cnt >= last) ? 4'h0 : 4'(s_q.cnt + 1'b1);
      // high for the first half; an odd ratio gets its extra half cycle below
      s_d.pos = (s_d.cnt < 4'((last + 4'h1) >> 1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // falling-edge copy stretches the odd high phase by half a cycle
  always_ff @(negedge aclk) begin
    if (!aresetn || !en) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= s_q.pos && odd;
    end
  end

  assign clk_out = s_q.pos || neg_q;
endmodule // clkout_divider

/* File: hdl/receiver_clock_divider_unit.sv */
// clock generation, mode control and receive timing of the receiver
//
// How it works
// - select 00 holds the clock output low, 01 divides the reference by 3, 10 by 6 and 11 by 12.
// - the clock output has an even high and low time for every ratio, including divide by three.
// - the clock output works in both standby and active mode, as the select allows.
// - the clock output toggles only after the oscillator-good flag is high and the select enables it.
// - the digital supply condition must also hold before the clock output is enabled.
// - all digital timing comes from one base clock at the reference divided by sixteen.
// - the range-scaled period is 8, 4, 2 or 1 base periods for ranges 0, 1, 2 and 3.
// - the bit-rate range is set by two select bits from the controller and scales start-up and debounce.
// - data debounce and the receive start-up interval are timed in range-scaled base-clock ticks.
// - the synthesizer feedback divides the local oscillator by 24 (315 MHz) or 32 (433.92 MHz).
// - with receive and enable both low the oscillator stops and no clock is output.
// - enable high with receive low is standby: oscillator runs, receive path stays off.
// - receive high is active mode: receive path on as well as the oscillator.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module receiver_clock_divider_unit
  import rcdu_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter bit VARIANT_433 = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog condition pins
  input wire logic osc_amplitude_good,
  input wire logic digital_core_supply,
  input wire logic local_oscillator,
  input wire logic rx_data_in,
  // clock and timing outputs
  output logic clkout,
  output logic osc_run,
  output logic rx_path_en,
  output logic digital_base_clock,
  output logic range_scaled_clock,
  output logic pll_compare_tick,
  // receive path outputs
  output logic rx_ready,
  output logic data_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] osc_sync;
    logic osc_good;
    logic [2:0] sup_sync;
    logic sup_good;
    logic [2:0] lo_sync;
    logic lo_level;
    logic [2:0] dat_sync;
    logic clkout_select_lsb;
    logic clkout_select_msb;
    logic rate_select_lsb;
    logic rate_select_msb;
    logic enable;
    logic rx;
    logic clk_en;
    logic [7:0] startup_cnt;
    logic rx_ready;
    logic [3:0] deb_cnt;
    logic data_out;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } unit_state_t;

  unit_state_t s_q, s_d;
  logic [1:0] clk_sel;
  logic [1:0] bit_rate_range;
  logic [3:0] range_last;
  logic base_tick;
  logic scaled_tick;
  logic lo_rise;
  logic dat_stable;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  assign clk_sel = {s_q.clkout_select_msb, s_q.clkout_select_lsb};
  assign bit_rate_range = {s_q.rate_select_msb, s_q.rate_select_lsb};
  assign osc_run = s_q.enable || s_q.rx;
  assign rx_path_en = s_q.rx;

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  always_comb begin
    unique case (bit_rate_range)
      2'h0: range_last = RANGE0_LAST;
      2'h1: range_last = RANGE1_LAST;
      2'h2: range_last = RANGE2_LAST;
      2'h3: range_last = RANGE3_LAST;
    endcase
  end

  // base clock runs only from a good oscillator
  tick_divider #(.W(4)) u_base_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(!s_q.osc_good),
    .step(1'b1),
    .last(BASE_LAST),
    .tick(base_tick)
  );

  tick_divider #(.W(4)) u_range_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(!s_q.osc_good),
    .step(base_tick),
    .last(range_last),
    .tick(scaled_tick)
  );

  // feedback divider only counts in active mode (receive on) with a good oscillator
  tick_divider #(.W(5)) u_fb_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(!s_q.osc_good || !s_q.rx),
    .step(lo_rise),
    .last(VARIANT_433 ? FB_LAST_433 : FB_LAST_315),
    .tick(pll_compare_tick)
  );

  clkout_divider u_clkout (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(s_q.clk_en),
    .sel(clk_sel),
    .clk_out(clkout)
  );

  assign digital_base_clock = base_tick;
  assign range_scaled_clock = scaled_tick;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // a level counts only once the second and third stages agree
  assign lo_rise = (s_q.lo_sync[1] == s_q.lo_sync[2]) && s_q.lo_sync[2] && !s_q.lo_level;
  assign dat_stable = (s_q.dat_sync[1] == s_q.dat_sync[2]);

  // ----------------------------------------------------------------
  // register words
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_CLKSEL_LSB +: 2] = clk_sel;
    ctrl_word[CTRL_RATE_LSB +: 2] = bit_rate_range;
    ctrl_word[CTRL_ENABLE_BIT] = s_q.enable;
    ctrl_word[CTRL_RX_BIT] = s_q.rx;
    status_word = '0;
    status_word[STAT_OSC_GOOD_BIT] = s_q.osc_good;
    status_word[STAT_SUPPLY_BIT] = s_q.sup_good;
    status_word[STAT_OSC_RUN_BIT] = osc_run;
    status_word[STAT_RX_PATH_BIT] = rx_path_en;
    status_word[STAT_RX_READY_BIT] = s_q.rx_ready;
    status_word[STAT_CLKOUT_EN_BIT] = s_q.clk_en;
    status_word[STAT_DATA_BIT] = s_q.data_out;
  end

  assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign rx_ready = s_q.rx_ready;
  assign data_out = s_q.data_out;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.osc_sync = {s_q.osc_sync[1:0], osc_amplitude_good};
    s_d.sup_sync = {s_q.sup_sync[1:0], digital_core_supply};
    s_d.lo_sync = {s_q.lo_sync[1:0], local_oscillator};
    s_d.dat_sync = {s_q.dat_sync[1:0], rx_data_in};
    // a stopped oscillator cannot report good amplitude
    if (!osc_run) begin
      s_d.osc_good = 1'b0;
    end else if (s_q.osc_sync[1] == s_q.osc_sync[2]) begin
      s_d.osc_good = s_q.osc_sync[2];
    end
    if (s_q.sup_sync[1] == s_q.sup_sync[2]) begin
      s_d.sup_good = s_q.sup_sync[2];
    end
    if (s_q.lo_sync[1] == s_q.lo_sync[2]) begin
      s_d.lo_level = s_q.lo_sync[2];
    end

    // clock output gate: oscillator good, supply good, select not off
    s_d.clk_en = s_q.osc_good && s_q.sup_good && osc_run && (clk_sel != CLKSEL_OFF);

    // receive start-up interval counted in scaled ticks
    if (!s_q.rx || !s_q.osc_good) begin
      s_d.startup_cnt = '0;
      s_d.rx_ready = 1'b0;
    end else if (scaled_tick && !s_q.rx_ready) begin
      s_d.startup_cnt = 8'(s_q.startup_cnt + 1'b1);
      s_d.rx_ready = (8'(s_q.startup_cnt + 1'b1) >= STARTUP_TICKS);
    end

    // data debounce: a new level must hold for a number of scaled ticks
    if (!s_q.rx_ready) begin
      s_d.deb_cnt = '0;
      s_d.data_out = 1'b0;
    end else if (!dat_stable || (s_q.dat_sync[2] == s_q.data_out)) begin
      s_d.deb_cnt = '0;
    end else if (scaled_tick) begin
      s_d.deb_cnt = 4'(s_q.deb_cnt + 1'b1);
      if (4'(s_q.deb_cnt + 1'b1) >= DEBOUNCE_TICKS) begin
        s_d.data_out = s_q.dat_sync[2];
        s_d.deb_cnt = '0;
      end
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_held && s_q.w_held) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.aw_addr == ADDR_W'(CTRL_OFFSET)) begin
        // only the low byte holds control bits
        if (s_q.wstrb[0]) begin
          s_d.clkout_select_lsb = s_q.wdata[CTRL_CLKSEL_LSB];
          s_d.clkout_select_msb = s_q.wdata[CTRL_CLKSEL_LSB + 1];
          s_d.rate_select_lsb = s_q.wdata[CTRL_RATE_LSB];
          s_d.rate_select_msb = s_q.wdata[CTRL_RATE_LSB + 1];
          s_d.enable = s_q.wdata[CTRL_ENABLE_BIT];
          s_d.rx = s_q.wdata[CTRL_RX_BIT];
        end
      end else if (s_q.aw_addr != ADDR_W'(STATUS_OFFSET)) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // read channel: one-cycle answer, held until taken
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(CTRL_OFFSET)) begin
        s_d.rdata = ctrl_word;
      end else if (s_axi_araddr == ADDR_W'(STATUS_OFFSET)) begin
        s_d.rdata = status_word;
      end else begin
        s_d.rdata = '0;
        s_d.rresp = RESP_SLVERR;
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.clkout_select_lsb <= CLKSEL_RESET[0];
      s_q.clkout_select_msb <= CLKSEL_RESET[1];
      s_q.rate_select_lsb <= RATE_RESET[0];
      s_q.rate_select_msb <= RATE_RESET[1];
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_clkout_off_low: assert property ((clk_sel == CLKSEL_OFF) [*3] |-> !clkout)
    else $error("clock output not low with select off");
  a_div3_period: assert property (($rose(clkout) && clk_sel == CLKSEL_DIV3 && s_q.clk_en) ##1
    (clk_sel == CLKSEL_DIV3 && s_q.clk_en) [*3] |-> $rose(clkout))
    else $error("divide by three period wrong");
  a_div6_high: assert property (($rose(clkout) && clk_sel == CLKSEL_DIV6) ##1
    (clk_sel == CLKSEL_DIV6 && s_q.clk_en) [*3] |-> !clkout && $past(clkout, 1) && $past(clkout, 3))
    else $error("divide by six high time wrong");
  a_clkout_gate: assert property ((!s_q.osc_good || !s_q.sup_good) [*3] |-> !clkout)
    else $error("clock output toggles without good oscillator and supply");
  a_clkout_enable: assert property ((s_q.osc_good && s_q.sup_good && osc_run && clk_sel != CLKSEL_OFF)
    [*2] |-> s_q.clk_en)
    else $error("clock output not enabled in standby or active");
  a_supply_needed: assert property (!s_q.sup_good |=> !s_q.clk_en)
    else $error("clock output enabled without supply");
  a_base_period: assert property ((base_tick && s_q.osc_good) ##1 s_q.osc_good [*8] ##1 s_q.osc_good [*8]
    |-> base_tick)
    else $error("base clock not reference over sixteen");
  a_range_fast: assert property (bit_rate_range == 2'h3 && base_tick |-> scaled_tick)
    else $error("range three scaled clock not equal to base");
  a_scaled_subset: assert property (scaled_tick |-> base_tick)
    else $error("scaled tick outside a base tick");
  a_off_no_osc: assert property (!s_q.enable && !s_q.rx |=> !s_q.osc_good)
    else $error("oscillator good in off mode");
  a_standby_path: assert property (s_q.enable && !s_q.rx |-> osc_run && !rx_path_en ##1 !s_q.rx_ready)
    else $error("receive path active in standby");
  a_held_dividers: assert property (!s_q.osc_good |-> !base_tick && !scaled_tick && !pll_compare_tick)
    else $error("divider ticks while oscillator not good");
  a_startup_wait: assert property ($rose(s_q.rx_ready) |-> s_q.startup_cnt == STARTUP_TICKS && rx_path_en)
    else $error("receive ready before start-up interval");
  a_bresp_hold: assert property (s_q.bvalid && !s_axi_bready |=> s_q.bvalid && $stable(s_q.bresp))
    else $error("write response dropped before taken");

  c_div3_run: cover property (s_q.clk_en && clk_sel == CLKSEL_DIV3 ##1 $rose(clkout));
  c_rx_ready: cover property ($rose(s_q.rx_ready));
  c_data_change: cover property ($changed(s_q.data_out) && s_q.rx_ready);
  c_fb_tick: cover property (pll_compare_tick);
endmodule // receiver_clock_divider_unit

/* File: dv/mcu_clock_monitor.sv */
// microcontroller side model: times the clock it is fed
`timescale 1ns/1ps
module mcu_clock_monitor (
  // clock from the receiver
  input wire logic clkout,
  // measured figures: high time and period in ns, rise count
  output int high_ns,
  output int period_ns,
  output int n_rises
);
  realtime rise_t;
  initial begin
    rise_t = 0.0;
    high_ns = 0;
    period_ns = 0;
    n_rises = 0;
  end
  // the controller runs from this clock, so an uneven duty shows up as a bad high time
  always @(posedge clkout) begin
    period_ns = int'($realtime - rise_t);
    rise_t = $realtime;
    n_rises = n_rises + 1;
  end
  always @(negedge clkout) begin
    high_ns = int'($realtime - rise_t);
  end
endmodule // mcu_clock_monitor

/* File: dv/testbench.sv */
// self-checking bench for the receiver clock divider unit
`timescale 1ns/1ps
module testbench
  import rcdu_pkg::*;
;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, lo_div;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic osc_amplitude_good, digital_core_supply, local_oscillator, rx_data_in, pulse_pick, lo_run;
  logic clkout, osc_run, rx_path_en, digital_base_clock, range_scaled_clock, pll_compare_tick, rx_ready, data_out;
  int fails, n_tests, cycles, high_ns, period_ns, n_rises, pick_sel, n_base, r0, b0, c, i, t;
  int div [4] = '{0, 3, 6, 12};

  receiver_clock_divider_unit #(.ADDR_W(8), .VARIANT_433(1'b0)) u_receiver_clock_divider_unit (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_amplitude_good, .digital_core_supply, .local_oscillator,
    .rx_data_in, .clkout, .osc_run, .rx_path_en, .digital_base_clock, .range_scaled_clock, .pll_compare_tick,
    .rx_ready, .data_out);
  mcu_clock_monitor u_mcu_clock_monitor (.clkout, .high_ns, .period_ns, .n_rises);

  // ----------------------------------------
  // clock, stimulus helpers, timeout
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // feedback pin rises every 4 cycles: slow enough for the 3-flop synchroniser
  always @(posedge aclk) begin
    lo_div <= lo_div + 2'h1;
    local_oscillator <= lo_run & lo_div[1];
  end
  always @(posedge aclk) if (digital_base_clock === 1'b1) n_base <= n_base + 1;
  always_comb pulse_pick = (pick_sel == 0) ? digital_base_clock :
    (pick_sel == 1) ? range_scaled_clock : pll_compare_tick;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_rng(input string what, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (aw_done && w_done && s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (t == 100) fails++;
    @(posedge aclk);
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (!s_axi_arvalid && s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t == 100) fails++;
    @(posedge aclk);
  endtask
  task set_ctrl(input logic [1:0] sel, input logic [1:0] rate, input logic en, input logic rx);
    axi_wr(CTRL_OFFSET, {26'h0, rx, en, rate, sel}, resp);
    chk("ctrl bresp", 32'(RESP_OKAY), 32'(resp));
  endtask
  // cycles between two pulses of the picked timing output
  task gap(input int which, output int cyc);
    pick_sel = which;
    cyc = 0;
    // the picked pulse only follows the new choice once the mux has settled
    @(posedge aclk);
    for (t = 0; t < 3000 && pulse_pick !== 1'b1; t++) @(posedge aclk);
    do begin
      @(posedge aclk);
      cyc++;
    end while (pulse_pick !== 1'b1 && cyc < 3000);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    axi_rd(CTRL_OFFSET, rd, resp);
    chk("ctrl reset", 32'h0, rd);
    chk("clkout reset", 32'h0, 32'(clkout));
    axi_wr(8'h08, 32'h1, resp);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
    axi_rd(8'h08, rd, resp);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
    axi_wr(STATUS_OFFSET, 32'hff, resp);
    chk("status bresp", 32'(RESP_OKAY), 32'(resp));
    $display("test reset done");
  endtask
  task t_off_and_gating();
    set_ctrl(CLKSEL_DIV3, 2'h0, 1'b0, 1'b0);
    r0 = n_rises;
    idle(200);
    chk("off osc_run", 32'h0, 32'(osc_run));
    chk("off rises", 32'(r0), 32'(n_rises));
    osc_amplitude_good <= 1'b0;
    set_ctrl(CLKSEL_DIV3, 2'h0, 1'b1, 1'b0);
    b0 = n_base;
    idle(200);
    chk("no osc rises", 32'(r0), 32'(n_rises));
    chk("no osc base", 32'(b0), 32'(n_base));
    osc_amplitude_good <= 1'b1;
    digital_core_supply <= 1'b0;
    b0 = n_base;
    idle(200);
    chk("no supply rises", 32'(r0), 32'(n_rises));
    chk_rng("base count", 10, 12, n_base - b0);
    digital_core_supply <= 1'b1;
    idle(60);
    chk_rng("clkout back", 1, 20, n_rises - r0);
    $display("test off_and_gating done");
  endtask
  task t_clkout();
    for (i = 1; i < 4; i++) begin
      set_ctrl(2'(i), 2'h0, 1'b1, 1'b0);
      r0 = n_rises;
      for (c = 0; c < 500 && n_rises < r0 + 4; c++) @(posedge aclk);
      chk("clkout period", 32'(div[i] * 4), 32'(period_ns));
      chk("clkout high", 32'(div[i] * 2), 32'(high_ns));
    end
    chk("standby rx path", 32'h0, 32'(rx_path_en));
    chk("standby osc", 32'h1, 32'(osc_run));
    set_ctrl(CLKSEL_OFF, 2'h0, 1'b1, 1'b0);
    idle(20);
    r0 = n_rises;
    idle(100);
    chk("sel off rises", 32'(r0), 32'(n_rises));
    chk("sel off level", 32'h0, 32'(clkout));
    $display("test clkout done");
  endtask
  task t_ranges();
    gap(0, c);
    chk("base period", 32'd16, 32'(c));
    for (i = 0; i < 4; i++) begin
      set_ctrl(CLKSEL_OFF, 2'(i), 1'b1, 1'b0);
      gap(1, c);
      gap(1, c);
      chk("scaled period", 32'((8 >> i) * 16), 32'(c));
    end
    $display("test ranges done");
  endtask
  task t_active();
    lo_run <= 1'b1;
    set_ctrl(CLKSEL_DIV3, 2'h3, 1'b1, 1'b1);
    for (c = 0; c < 3000 && rx_ready !== 1'b1; c++) @(posedge aclk);
    chk_rng("startup cycles", 64 * 16 - 32, 64 * 16 + 64, c);
    chk("active rx path", 32'h1, 32'(rx_path_en));
    r0 = n_rises;
    idle(40);
    chk_rng("active rises", 12, 14, n_rises - r0);
    gap(2, c);
    chk("pll compare", 32'd96, 32'(c));
    axi_rd(STATUS_OFFSET, rd, resp);
    chk("status active", 32'h3f, rd & 32'h7f);
    rx_data_in <= 1'b1;
    idle(20);
    rx_data_in <= 1'b0;
    idle(120);
    chk("glitch held", 32'h0, 32'(data_out));
    rx_data_in <= 1'b1;
    idle(30);
    chk("debounce early", 32'h0, 32'(data_out));
    for (c = 0; c < 300 && data_out !== 1'b1; c++) @(posedge aclk);
    chk_rng("debounce late", 10, 80, c);
    $display("test active done");
  endtask

  task print_verdict();
    $display("checks %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {osc_amplitude_good, digital_core_supply, rx_data_in, lo_run, local_oscillator} = 5'h18;
    lo_div = 2'h0;
    {fails, n_tests, cycles, n_base} = 128'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_off_and_gating();
    t_clkout();
    t_ranges();
    t_active();
    print_verdict();
  end
endmodule // testbench
